// file: src/cap_pkg.sv
// shared constants, register map and state codes for the pulse monitor
package cap_pkg;
    // clock and timing base
    localparam int CLK_PERIOD_NS = 40;          // 25 MHz core clock
    localparam int TICK_NS = 100_000_000;       // 0.1 s timing base
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_MS = 100;               // tick length in ms
    // pulse times in ms, converted to ticks below
    localparam int CYCLE_MS = 20000;            // one whole monitor cycle
    localparam int START_MS = 1000;             // start pulse
    localparam int INV_HIGH_MS = 3500;          // invalid-data high pulse
    localparam int LOW_MIN_MS = 500;            // current pulse floor
    localparam int LOW_MAX_MS = 9000;           // current pulse ceiling
    localparam int HIGH_MIN_MS = 2000;          // maintenance pulse floor
    localparam int HIGH_MAX_MS = 9000;          // maintenance pulse ceiling
    localparam int FULL_SCALE_MS = 5000;        // 100 percent equals 5 s
    localparam logic [7:0] CYCLE_TICKS = 8'(CYCLE_MS / TICK_MS);
    localparam logic [7:0] START_TICKS = 8'(START_MS / TICK_MS);
    localparam logic [7:0] INVH_TICKS = 8'(INV_HIGH_MS / TICK_MS);
    localparam logic [7:0] LOW_MIN = 8'(LOW_MIN_MS / TICK_MS);
    localparam logic [7:0] LOW_MAX = 8'(LOW_MAX_MS / TICK_MS);
    localparam logic [7:0] HIGH_MIN = 8'(HIGH_MIN_MS / TICK_MS);
    localparam logic [7:0] HIGH_MAX = 8'(HIGH_MAX_MS / TICK_MS);
    localparam logic [7:0] FULL_TICKS = 8'(FULL_SCALE_MS / TICK_MS);
    // maintenance count is in 100 h units, full scale 40000 h
    localparam int MAINT_UNIT_H = 100;
    localparam int MAINT_FULL_H = 40000;
    localparam logic [13:0] MAINT_DIV =
        14'(MAINT_FULL_H / MAINT_UNIT_H / (FULL_SCALE_MS / TICK_MS));
    // restart setting value that switches automatic restart off
    localparam logic [13:0] RESTART_OFF = 14'h270F;
    // register byte offsets
    localparam logic [7:0] OFS_AVG_WIN = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_REF = 8'h08;
    localparam logic [7:0] OFS_MAINT = 8'h0C;
    localparam logic [7:0] OFS_RESTART = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // reset values and write limits
    localparam logic [3:0] RST_AVG_WIN = 4'hA;  // 1.0 s
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [13:0] RST_MAINT = 14'h0000;
    localparam logic [3:0] AVG_MAX = 4'hA;      // 10 ticks at most
    localparam logic [7:0] MASK_MAX = 8'hC8;    // 20.0 s
    // status field positions
    localparam int ST_HIGH_LSB = 0;
    localparam int ST_LOW_LSB = 8;
    localparam int ST_OUT_BIT = 16;
    localparam int ST_RST_BIT = 17;
    localparam int ST_STATE_LSB = 20;
    // AHB transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE = 1;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,   // waiting for constant speed
        ST_ZWAIT = 4'h1,  // zero current, wait for next constant speed
        ST_MASK = 4'h2,   // transient mask running
        ST_START = 4'h3,  // start pulse, current sampled
        ST_LOWD = 4'h4,   // current-coded low pulse
        ST_HIGHD = 4'h5,  // maintenance-coded high pulse
        ST_ENDL = 4'h6,   // end low until the cycle closes
        ST_INVH = 4'h7,   // invalid data high pulse
        ST_INVL = 4'h8,   // invalid data end low
        ST_NODATA = 4'h9  // data-less low cycle
    } cap_state_t;
endpackage : cap_pkg

// file: src/cap_tick_gen.sv
// free-running timing base that pulses once per tick period
`timescale 1ns/1ps
module cap_tick_gen
    import cap_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    output logic tick
);
    logic [31:0] divCnt_ff; // cycles since the last tick

    // count core cycles, wrap at the tick length
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            divCnt_ff <= 32'h0;
        end
        else if (clkEn)
        begin
            if (divCnt_ff == 32'(TICK_LEN - 1))
                divCnt_ff <= 32'h0;
            else
                divCnt_ff <= divCnt_ff + 32'h1;
        end
    end

    // pulse is gated so a frozen block sees no tick
    assign tick = clkEn && (divCnt_ff == 32'(TICK_LEN - 1));
endmodule : cap_tick_gen

// file: src/cap_monitor.sv
// current average pulse monitor with AHB-Lite settings registers
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module cap_monitor
    import cap_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int CUR_W = 10,
    parameter logic [8:0] REF_DEFAULT = 9'h064
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic constSpeed,
    input wire logic restartActive,
    input wire logic [CUR_W-1:0] outputCurrent,
    output logic current_average_monitor_output,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // settings registers
    logic [3:0] averaging_window_time_ff;    // ticks of 0.1 s
    logic [7:0] transient_mask_time_ff;      // ticks of 0.1 s
    logic [8:0] reference_current_setting_ff; // amperes
    logic [13:0] maintenance_hours_count_ff; // 100 h units
    logic [13:0] restart_coasting_setting_ff; // off at the reserved value
    // bus data-phase state
    logic wrPend_ff;
    logic [7:0] wrAddr_ff;
    // sequencer state
    cap_state_t state_ff;
    cap_state_t nxt_state;
    logic [7:0] phaseCnt_ff;                 // ticks in the current state
    logic [7:0] cycleCnt_ff;                 // ticks in the current cycle
    logic [CUR_W+3:0] curSum_ff;             // sampled current sum
    logic [7:0] lowTicks_ff;
    logic [7:0] highTicks_ff;
    logic monOut_ff;
    logic tick;
    logic restartOn;
    logic cycleEnd;
    logic stateChange;
    logic [3:0] avgCount;
    logic [7:0] lowCalc;
    logic [7:0] highCalc;
    cap_state_t endChoice;
    logic busTake;

    // output level of each state; start and high pulses drive high
    function automatic logic levelOf(input cap_state_t s);
        levelOf = (s == ST_START) || (s == ST_HIGHD) || (s == ST_INVH);
    endfunction : levelOf

    // states that belong to a running 20 s cycle
    function automatic logic inCycle(input cap_state_t s);
        inCycle = (s != ST_IDLE) && (s != ST_ZWAIT) && (s != ST_MASK);
    endfunction : inCycle

    // clamp a tick count into a window
    function automatic logic [7:0] clampTicks(input logic [19:0] v,
                                              input logic [7:0] lo,
                                              input logic [7:0] hi);
        if (v < 20'(lo))
            clampTicks = lo;
        else if (v > 20'(hi))
            clampTicks = hi;
        else
            clampTicks = v[7:0];
    endfunction : clampTicks

    cap_tick_gen #(
        .TICK_LEN(TICK_LEN)
    ) u_tick (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .tick(tick)
    );

    assign restartOn = (restart_coasting_setting_ff != RESTART_OFF);
    // a zero window is read as one tick so the average stays defined
    assign avgCount = (averaging_window_time_ff == 4'h0) ? 4'h1 :
                      averaging_window_time_ff;

    // pulse lengths from the averaged current and maintenance count
    always_comb
    begin
        logic [19:0] num;
        logic [19:0] den;
        num = 20'(curSum_ff) * 20'(FULL_TICKS);
        den = 20'(avgCount) * 20'(reference_current_setting_ff);
        // zero reference means any current is far above 180 percent
        if (den == 20'h0)
            lowCalc = LOW_MAX;
        else
            lowCalc = clampTicks(num / den, LOW_MIN, LOW_MAX);
        highCalc = clampTicks(20'(maintenance_hours_count_ff / MAINT_DIV),
                              HIGH_MIN, HIGH_MAX);
    end

    assign cycleEnd = tick && inCycle(state_ff) &&
                      (cycleCnt_ff == CYCLE_TICKS - 8'h1);

    // what follows a completed cycle
    always_comb
    begin
        if (outputCurrent == '0)
            endChoice = ST_ZWAIT;
        else if (!constSpeed)
            endChoice = ST_NODATA;
        else if (restartOn && restartActive)
            endChoice = ST_NODATA;
        else
            endChoice = ST_START;
    end

    // sequencer next state
    always_comb
    begin
        nxt_state = state_ff;
        if (clkEn)
        begin
            unique case (state_ff)
                ST_IDLE:
                    if (constSpeed)
                        nxt_state = ST_MASK;
                ST_ZWAIT:
                    if (!constSpeed)
                        nxt_state = ST_IDLE;
                ST_MASK:
                    // a speed change abandons the mask entirely
                    if (!constSpeed)
                        nxt_state = ST_IDLE;
                    else if (phaseCnt_ff >= transient_mask_time_ff)
                        nxt_state = (restartOn && restartActive) ?
                                    ST_NODATA : ST_START;
                ST_START:
                    if (!constSpeed)
                        nxt_state = ST_INVH;
                    else if (tick && phaseCnt_ff == START_TICKS - 8'h1)
                        nxt_state = ST_LOWD;
                ST_LOWD:
                    if (tick && phaseCnt_ff == lowTicks_ff - 8'h1)
                        nxt_state = ST_HIGHD;
                ST_HIGHD:
                    if (tick && phaseCnt_ff == highTicks_ff - 8'h1)
                        nxt_state = ST_ENDL;
                ST_INVH:
                    if (tick && cycleCnt_ff == INVH_TICKS - 8'h1)
                        nxt_state = ST_INVL;
                ST_ENDL, ST_INVL, ST_NODATA:
                    // speed is ignored until the cycle has closed
                    if (cycleEnd)
                        nxt_state = endChoice;
                default:
                    nxt_state = ST_IDLE;
            endcase
        end
    end

    assign stateChange = (nxt_state != state_ff);

    // state register and registered monitor output
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            monOut_ff <= 1'b0;
        end
        else if (clkEn)
        begin
            state_ff <= nxt_state;
            monOut_ff <= levelOf(nxt_state);
        end
    end

    // tick counters; a repeated data-less cycle restarts both
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            phaseCnt_ff <= 8'h00;
            cycleCnt_ff <= 8'h00;
        end
        else if (clkEn)
        begin
            if (stateChange || cycleEnd)
                phaseCnt_ff <= 8'h00;
            else if (tick)
                phaseCnt_ff <= phaseCnt_ff + 8'h01;
            // a new cycle starts at start pulse or data-less entry
            if (cycleEnd || (stateChange && (nxt_state == ST_START ||
                                             nxt_state == ST_NODATA)))
                cycleCnt_ff <= 8'h00;
            else if (tick && inCycle(state_ff))
                cycleCnt_ff <= cycleCnt_ff + 8'h01;
        end
    end

    // current sampling during the averaging window of the start pulse
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            curSum_ff <= '0;
        end
        else if (clkEn)
        begin
            if (stateChange && nxt_state == ST_START)
                curSum_ff <= '0;
            else if (state_ff == ST_START && constSpeed && tick &&
                     phaseCnt_ff < 8'(avgCount))
                curSum_ff <= curSum_ff + (CUR_W+4)'(outputCurrent);
        end
    end

    // pulse lengths latched in the first tick of the low pulse, so the
    // sample taken on the start pulse's closing tick is in the sum
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lowTicks_ff <= LOW_MIN;
            highTicks_ff <= HIGH_MIN;
        end
        else if (clkEn && state_ff == ST_LOWD && phaseCnt_ff == 8'h00)
        begin
            lowTicks_ff <= lowCalc;
            highTicks_ff <= highCalc;
        end
    end

    assign current_average_monitor_output = monOut_ff;

    // bus: no wait states, but a frozen block holds the bus off
    assign hreadyout = clkEn;
    assign hresp = 1'b0;
    assign busTake = hsel && hready && htrans[HTRANS_ACTIVE];

    // address phase capture and registered read data
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            hrdata <= 32'h0;
        end
        else if (clkEn)
        begin
            wrPend_ff <= busTake && hwrite;
            wrAddr_ff <= haddr[7:0];
            if (busTake && !hwrite)
            begin
                unique case (haddr[7:0])
                    OFS_AVG_WIN: hrdata <= 32'(averaging_window_time_ff);
                    OFS_MASK: hrdata <= 32'(transient_mask_time_ff);
                    OFS_REF: hrdata <= 32'(reference_current_setting_ff);
                    OFS_MAINT: hrdata <= 32'(maintenance_hours_count_ff);
                    OFS_RESTART: hrdata <= 32'(restart_coasting_setting_ff);
                    OFS_STATUS:
                    begin
                        hrdata <= 32'h0;
                        hrdata[ST_HIGH_LSB +: 8] <= highTicks_ff;
                        hrdata[ST_LOW_LSB +: 8] <= lowTicks_ff;
                        hrdata[ST_OUT_BIT] <= monOut_ff;
                        hrdata[ST_RST_BIT] <= restartOn;
                        hrdata[ST_STATE_LSB +: 4] <= state_ff;
                    end
                    // unmapped offsets read as zero
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    // settings writes in the data phase; status is read only
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            averaging_window_time_ff <= RST_AVG_WIN;
            transient_mask_time_ff <= RST_MASK;
            reference_current_setting_ff <= REF_DEFAULT;
            maintenance_hours_count_ff <= RST_MAINT;
            restart_coasting_setting_ff <= RESTART_OFF;
        end
        else if (clkEn && wrPend_ff)
        begin
            unique case (wrAddr_ff)
                OFS_AVG_WIN:
                    // out-of-range window saturates at 1.0 s
                    averaging_window_time_ff <= (hwdata[3:0] > AVG_MAX) ?
                                                AVG_MAX : hwdata[3:0];
                OFS_MASK:
                    transient_mask_time_ff <= (hwdata[7:0] > MASK_MAX) ?
                                              MASK_MAX : hwdata[7:0];
                OFS_REF: reference_current_setting_ff <= hwdata[8:0];
                OFS_MAINT: maintenance_hours_count_ff <= hwdata[13:0];
                OFS_RESTART: restart_coasting_setting_ff <= hwdata[13:0];
                default: ;
            endcase
        end
    end

    // checks next to the sequencer
    a_mask_abort: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && state_ff == ST_MASK && !constSpeed |=> state_ff == ST_IDLE)
        else $error("mask kept running during a speed change");
    a_invalid_start: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && state_ff == ST_START && !constSpeed
        |=> state_ff == ST_INVH && current_average_monitor_output)
        else $error("speed change in start pulse not flagged");
    a_invalid_high_len: assert property (@(posedge core_clk)
        disable iff (rst)
        state_ff == ST_INVH && tick && cycleCnt_ff == INVH_TICKS - 8'h1
        |=> state_ff == ST_INVL && !current_average_monitor_output)
        else $error("invalid high pulse length wrong");
    a_cycle_held: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && state_ff == ST_INVL && !cycleEnd |=> state_ff == ST_INVL)
        else $error("invalid cycle cut short");
    a_zero_current: assert property (@(posedge core_clk) disable iff (rst)
        cycleEnd && outputCurrent == '0 |=> state_ff == ST_ZWAIT)
        else $error("zero current did not stop the monitor");
    a_nodata_accel: assert property (@(posedge core_clk) disable iff (rst)
        cycleEnd && outputCurrent != '0 && !constSpeed
        |=> state_ff == ST_NODATA && !current_average_monitor_output)
        else $error("no data-less cycle while accelerating");
    a_nodata_restart: assert property (@(posedge core_clk)
        disable iff (rst)
        cycleEnd && outputCurrent != '0 && restartOn && restartActive
        |=> state_ff == ST_NODATA)
        else $error("restart at cycle end gave data");
    a_mask_restart: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && state_ff == ST_MASK && constSpeed && restartOn &&
        restartActive && phaseCnt_ff >= transient_mask_time_ff
        |=> state_ff == ST_NODATA)
        else $error("restart at mask end gave data");
    a_cycle_bound: assert property (@(posedge core_clk) disable iff (rst)
        cycleCnt_ff < CYCLE_TICKS)
        else $error("cycle ran past 20 s");
    a_start_level: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == ST_START |-> current_average_monitor_output)
        else $error("start pulse not high");
    a_low_clamp: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == ST_LOWD |-> lowTicks_ff >= LOW_MIN &&
        lowTicks_ff <= LOW_MAX && !current_average_monitor_output)
        else $error("current pulse out of range");
    a_high_clamp: assert property (@(posedge core_clk) disable iff (rst)
        state_ff == ST_HIGHD |-> highTicks_ff >= HIGH_MIN &&
        highTicks_ff <= HIGH_MAX)
        else $error("maintenance pulse out of range");
    a_idle_to_mask: assert property (@(posedge core_clk) disable iff (rst)
        clkEn && state_ff == ST_IDLE && constSpeed |=> state_ff == ST_MASK)
        else $error("constant speed did not start the mask");
endmodule : cap_monitor

// file: bench/cap_plc_model.sv
// controller input model that times each level of the monitor pulse
`timescale 1ns/1ps
module cap_plc_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic monIn,
    output logic [31:0] highLen_ff,
    output logic [31:0] lowLen_ff
);
    logic [31:0] run_ff; // cycles spent at the present level
    logic prev_ff; // level seen at the last edge

    // latch a level's length at each change; reading is in whole cycles
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            run_ff <= 32'h0;
            prev_ff <= 1'b0;
            highLen_ff <= 32'h0;
            lowLen_ff <= 32'h0;
        end
        else if (monIn != prev_ff)
        begin
            // the input module only sees edges, so a level is timed whole
            if (prev_ff)
                highLen_ff <= run_ff + 32'h1;
            else
                lowLen_ff <= run_ff + 32'h1;
            run_ff <= 32'h0;
            prev_ff <= monIn;
        end
        else
            run_ff <= run_ff + 32'h1;
    end
endmodule : cap_plc_model

// file: bench/cap_monitor_tb_top.sv
// self-checking bench for the current average pulse monitor
`timescale 1ns/1ps
module cap_monitor_tb_top;
    import cap_pkg::*;
    localparam int TL = 10; // short tick keeps the 20 s cycle brief
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic constSpeed = 1'b0;
    logic restartActive = 1'b0;
    logic [9:0] outputCurrent = 10'h096; // 150 A
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic monOut;
    logic [31:0] hrdata;
    logic [31:0] highLen;
    logic [31:0] lowLen;
    logic [31:0] rdata;
    int failures = 0;
    int n_checks = 0;
    int waited; // cycles spent in the last level wait

    // 25 MHz clock
    always #20 core_clk = ~core_clk;

    cap_monitor #(.TICK_LEN(TL)) cap_monitor_i (
        .core_clk(core_clk), .rst(rst), .clkEn(1'b1),
        .constSpeed(constSpeed), .restartActive(restartActive),
        .outputCurrent(outputCurrent),
        .current_average_monitor_output(monOut),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    cap_plc_model cap_plc_model_i (
        .core_clk(core_clk), .rst(rst), .monIn(monOut),
        .highLen_ff(highLen), .lowLen_ff(lowLen));

    // range compare; an unknown never lands inside the range
    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        n_checks++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
        begin
            failures++;
            $display("[ERR] %0t got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : chk

    // let n rising edges pass
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // one single AHB-Lite word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] ofs,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    // read one register and compare
    task automatic rdc(input logic [7:0] ofs, input int e);
        logic [31:0] v;
        bus(1'b0, ofs, 32'h0, v);
        chk(v, e, e);
        chk({31'h0, hresp}, 0, 0);
    endtask : rdc

    // wait, bounded, for the monitor output to reach a level
    task automatic waitLvl(input logic lvl);
        waited = 0;
        while (monOut !== lvl && waited < 4000)
        begin
            @(negedge core_clk);
            waited++;
        end
        chk({31'h0, monOut}, lvl, lvl);
        // one more edge so the controller model has latched the length
        @(posedge core_clk);
        #1;
    endtask : waitLvl

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        rdc(OFS_AVG_WIN, 10);
        bus(1'b1, OFS_AVG_WIN, 32'h0000000F, rdata);
        rdc(OFS_AVG_WIN, 10);
        rdc(8'h18, 0);
        rdc(OFS_REF, 100);
        rdc(OFS_RESTART, 32'h270F);
        @(posedge core_clk);
        constSpeed <= 1'b1;
        // normal cycle: 150 A against 100 A gives 7.5 s
        waitLvl(1'b1);
        waitLvl(1'b0);
        chk(highLen, 9 * TL, 10 * TL);
        waitLvl(1'b1);
        chk(lowLen, 75 * TL, 75 * TL);
        waitLvl(1'b0);
        chk(highLen, 20 * TL, 20 * TL);
        // restart running when the cycle closes
        bus(1'b1, OFS_RESTART, 32'h00000005, rdata);
        restartActive <= 1'b1;
        cyc(190 * TL);
        restartActive <= 1'b0;
        waitLvl(1'b1);
        chk(lowLen, 294 * TL, 296 * TL);
        // speed lost during the start pulse
        cyc(3 * TL);
        constSpeed <= 1'b0;
        waitLvl(1'b0);
        chk(highLen, 34 * TL, 36 * TL);
        cyc(250 * TL);
        outputCurrent <= 10'h005;
        constSpeed <= 1'b1;
        waitLvl(1'b1);
        chk(lowLen, 364 * TL, 366 * TL);
        // 5 A is under 10 percent, then zero current at cycle end
        waitLvl(1'b0);
        waitLvl(1'b1);
        chk(lowLen, 5 * TL, 5 * TL);
        outputCurrent <= 10'h000;
        waitLvl(1'b0);
        cyc(250 * TL);
        chk({31'h0, monOut}, 0, 0);
        bus(1'b0, OFS_STATUS, 32'h0, rdata);
        chk({28'h0, rdata[23:20]}, 1, 1);
        // mask of 0.5 s before the next start
        bus(1'b1, OFS_MASK, 32'h00000005, rdata);
        constSpeed <= 1'b0;
        cyc(2);
        constSpeed <= 1'b1;
        waitLvl(1'b1);
        chk(waited, 4 * TL, 7 * TL);
        // zero current closes this cycle into the zero wait again
        cyc(205 * TL);
        // restart still running as the mask closes: data-less cycle
        restartActive <= 1'b1;
        constSpeed <= 1'b0;
        cyc(2);
        constSpeed <= 1'b1;
        cyc(10 * TL);
        chk({31'h0, monOut}, 0, 0);
        bus(1'b0, OFS_STATUS, 32'h0, rdata);
        chk({28'h0, rdata[23:20]}, 9, 9);
        complete_run();
    end

    // hang guard, well past the expected run length
    initial
    begin
        repeat (30000) @(posedge core_clk);
        failures++;
        complete_run();
    end
endmodule : cap_monitor_tb_top
